// [inc/mis_map.svh]
// Behaviour
// - Summary bit seven set by enabled flags
// - Summary clears itself when enabled flags clear
// - Fault mode change sets low bit five
// - Reactive sign change sets low bit four
// - Active sign change sets low bit three
// - Apparent no-load sets low bit two
// - Reactive no-load sets low bit one
// - Active no-load sets low bit zero
// - Second pulse sets mid bit seven always
// - First pulse sets mid bit six always
// - Energy overflows set mid bits five-three
// - Energy half-full sets mid bits two-zero
// - Reset end sets high bit seven
// - New waveform samples set high bit five
// - Current peak sets high bit four
// - Voltage peak sets high bit three
// - Line cycle accumulation end sets bit two
// - Zero-cross timeout sets high bit one
// - Zero crossing sets high bit zero
// - Low enables five-zero gate low flags
// - Mid enables seven-six gate pulse flags
// - Mid enables five-zero gate energy flags
// - High enables five-zero gate high flags
`ifndef MIS_MAP_SVH
`define MIS_MAP_SVH

// Register offsets on the special function bus
`define MIS_OFS_EN_LOW   8'hd9
`define MIS_OFS_EN_MID   8'hda
`define MIS_OFS_EN_HIGH  8'hdb
`define MIS_OFS_ST_LOW   8'hdc
`define MIS_OFS_ST_MID   8'hdd
`define MIS_OFS_ST_HIGH  8'hde

// Implemented bits of each register
`define MIS_EN_LOW_MASK  8'h3f
`define MIS_EN_MID_MASK  8'hff
`define MIS_EN_HIGH_MASK 8'h3f
`define MIS_ST_LOW_IMPL  8'h3f
`define MIS_ST_MID_IMPL  8'hff
`define MIS_ST_HIGH_IMPL 8'hbf

// Reset values
`define MIS_EN_RST       8'h00
`define MIS_ST_RST       8'h00
`define MIS_ST_HIGH_RST  8'h80
`define MIS_ZERO8        8'h00

// Bit positions
`define MIS_BIT_SUMMARY  7
`define MIS_BIT_RST_END  7
`define MIS_BIT_B7       7
`define MIS_BIT_B6       6
`define MIS_BIT_B5       5
`define MIS_BIT_B4       4
`define MIS_BIT_B3       3
`define MIS_BIT_B2       2
`define MIS_BIT_B1       1
`define MIS_BIT_B0       0
`define MIS_FREQ_A       0
`define MIS_FREQ_B       1

`endif

// [inc/mis_pkg.sv]
package mis_pkg;

  // Register access from the processor core
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } mis_sfr_s;

  // Sign and fault levels from the metering datapath
  typedef struct packed {
    logic fault_mode;
    logic reactive_sign;
    logic active_sign;
  } mis_sign_s;

  // One-cycle event pulses from the metering datapath
  typedef struct packed {
    logic apparent_noload;
    logic reactive_noload;
    logic active_noload;
    logic freq_pulse_b;
    logic freq_pulse_a;
    logic apparent_energy_overflow;
    logic reactive_energy_overflow;
    logic active_energy_overflow;
    logic apparent_energy_half;
    logic reactive_energy_half;
    logic active_energy_half;
    logic soft_reset_done;
    logic waveform_sample_ready;
    logic current_peak_exceeded;
    logic voltage_peak_exceeded;
    logic line_cycle_accum_done;
    logic zero_cross_timeout;
    logic zero_cross_detect;
  } mis_event_s;

  // State of one sticky flag byte
  typedef struct packed {
    logic [7:0] flags;
  } mis_flag_state_s;

  // State of the controller
  typedef struct packed {
    logic [7:0] en_low;
    logic [7:0] en_mid;
    logic [7:0] en_high;
    logic [2:0] sign_q;
    logic       sign_armed;
    logic [7:0] rdata;
    logic       rvalid;
    logic       pulse_a;
    logic       pulse_b;
  } mis_state_s;

endpackage

// [rtl/mis_flag_byte.sv]
`timescale 1ns/1ns
`default_nettype none
module mis_flag_byte #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] IMPL_MASK = 8'hff
) (
  input  wire logic       clk_i,   // Core clock
  input  wire logic       reset_i, // Synchronous reset
  input  wire logic       ce_i,    // Clock enable
  input  wire logic [7:0] set_i,   // Flag set pulses
  input  wire logic [7:0] clr_i,   // Flag clear strobes
  output logic      [7:0] flags_o  // Sticky flags
);
  import mis_pkg::*;

  mis_flag_state_s st;
  mis_flag_state_s next_st;

  // Set beats clear so an event in the clear cycle survives
  // sticky until cleared
  always_comb begin
    next_st       = st;
    next_st.flags = ((st.flags & ~clr_i) | set_i) & IMPL_MASK;
  end

  // Register the flags; low ce_i freezes them
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st.flags <= RESET_VAL;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign flags_o = st.flags;
endmodule
`default_nettype wire

// [rtl/mis_irq_ctrl.sv]
`include "mis_map.svh"
`timescale 1ns/1ns
`default_nettype none
module mis_irq_ctrl (
  input  wire logic               clk_i,          // Core clock
  input  wire logic               reset_i,        // Synchronous reset
  input  wire logic               ce_i,           // Clock enable
  input  wire mis_pkg::mis_sfr_s   sfr_i,          // Register access
  output logic      [7:0]         sfr_rdata_o,    // Read data
  output logic                    sfr_rvalid_o,   // Read data valid
  output logic                    sfr_hit_o,      // Address decoded
  input  wire mis_pkg::mis_sign_s  sign_i,         // Sign levels
  input  wire mis_pkg::mis_event_s event_i,        // Event pulses
  input  wire logic [1:0]         freq_out_en_i,  // Pulse pin enables
  output logic                    freq_pulse_a_o, // First pulse out
  output logic                    freq_pulse_b_o, // Second pulse out
  output logic                    irq_o           // Interrupt request
);
  import mis_pkg::*;

  mis_state_s st;
  mis_state_s next_st;

  // Flag bytes and their set and clear vectors
  logic [7:0] st_low;
  logic [7:0] st_mid;
  logic [7:0] st_high;
  logic [7:0] set_low;
  logic [7:0] set_mid;
  logic [7:0] set_high;
  logic [7:0] clr_low;
  logic [7:0] clr_mid;
  logic [7:0] clr_high;

  // Decoded accesses
  logic       hit_en_low;
  logic       hit_en_mid;
  logic       hit_en_high;
  logic       hit_st_low;
  logic       hit_st_mid;
  logic       hit_st_high;
  logic       any_hit;

  // Sign change detection
  logic [2:0] sign_now;
  logic [2:0] sign_chg;

  // Masked flags and summary
  logic [7:0] pend_low;
  logic [7:0] pend_mid;
  logic [7:0] pend_high;
  logic       summary;
  logic [7:0] st_low_view;
  logic [7:0] read_val;

  // Address decode for the six registers
  assign hit_en_low  = (sfr_i.addr == `MIS_OFS_EN_LOW);
  assign hit_en_mid  = (sfr_i.addr == `MIS_OFS_EN_MID);
  assign hit_en_high = (sfr_i.addr == `MIS_OFS_EN_HIGH);
  assign hit_st_low  = (sfr_i.addr == `MIS_OFS_ST_LOW);
  assign hit_st_mid  = (sfr_i.addr == `MIS_OFS_ST_MID);
  assign hit_st_high = (sfr_i.addr == `MIS_OFS_ST_HIGH);
  assign any_hit     = hit_en_low | hit_en_mid | hit_en_high |
                       hit_st_low | hit_st_mid | hit_st_high;

  // Sign levels arrive settled, the accumulation mode already
  // applied upstream, so only the change is judged here
  assign sign_now = {sign_i.fault_mode, sign_i.reactive_sign,
                     sign_i.active_sign};
  // Armed only after the first sample, so reset is not a change
  assign sign_chg = (sign_now ^ st.sign_q) & {3{st.sign_armed}};

  // Low status byte set sources
  always_comb begin
    set_low = `MIS_ZERO8;
    set_low[`MIS_BIT_B5] = sign_chg[2];
    set_low[`MIS_BIT_B4] = sign_chg[1];
    set_low[`MIS_BIT_B3] = sign_chg[0];
    set_low[`MIS_BIT_B2] = event_i.apparent_noload;
    set_low[`MIS_BIT_B1] = event_i.reactive_noload;
    set_low[`MIS_BIT_B0] = event_i.active_noload;
  end

  // Mid status byte set sources; pulse flags ignore pin enables
  always_comb begin
    set_mid = `MIS_ZERO8;
    set_mid[`MIS_BIT_B7] = event_i.freq_pulse_b;
    set_mid[`MIS_BIT_B6] = event_i.freq_pulse_a;
    set_mid[`MIS_BIT_B5] = event_i.apparent_energy_overflow;
    set_mid[`MIS_BIT_B4] = event_i.reactive_energy_overflow;
    set_mid[`MIS_BIT_B3] = event_i.active_energy_overflow;
    set_mid[`MIS_BIT_B2] = event_i.apparent_energy_half;
    set_mid[`MIS_BIT_B1] = event_i.reactive_energy_half;
    set_mid[`MIS_BIT_B0] = event_i.active_energy_half;
  end

  // High status byte set sources
  always_comb begin
    set_high = `MIS_ZERO8;
    // software reset end; hardware reset loads it set
    set_high[`MIS_BIT_RST_END] = event_i.soft_reset_done;
    set_high[`MIS_BIT_B5] = event_i.waveform_sample_ready;
    set_high[`MIS_BIT_B4] = event_i.current_peak_exceeded;
    set_high[`MIS_BIT_B3] = event_i.voltage_peak_exceeded;
    set_high[`MIS_BIT_B2] = event_i.line_cycle_accum_done;
    set_high[`MIS_BIT_B1] = event_i.zero_cross_timeout;
    set_high[`MIS_BIT_B0] = event_i.zero_cross_detect;
  end

  // A status write clears each flag written as zero and leaves
  // flags written as one, so bit-clear instructions are safe
  // software clear
  assign clr_low  = (sfr_i.wr && hit_st_low)  ? ~sfr_i.wdata
                                              : `MIS_ZERO8;
  assign clr_mid  = (sfr_i.wr && hit_st_mid)  ? ~sfr_i.wdata
                                              : `MIS_ZERO8;
  assign clr_high = (sfr_i.wr && hit_st_high) ? ~sfr_i.wdata
                                              : `MIS_ZERO8;

  // Three sticky flag bytes
  mis_flag_byte #(
    .RESET_VAL (`MIS_ST_RST),
    .IMPL_MASK (`MIS_ST_LOW_IMPL)
  ) u_st_low (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .set_i   (set_low),
    .clr_i   (clr_low),
    .flags_o (st_low)
  );

  mis_flag_byte #(
    .RESET_VAL (`MIS_ST_RST),
    .IMPL_MASK (`MIS_ST_MID_IMPL)
  ) u_st_mid (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .set_i   (set_mid),
    .clr_i   (clr_mid),
    .flags_o (st_mid)
  );

  // Reset-end flag comes out of reset already set
  mis_flag_byte #(
    .RESET_VAL (`MIS_ST_HIGH_RST),
    .IMPL_MASK (`MIS_ST_HIGH_IMPL)
  ) u_st_high (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .set_i   (set_high),
    .clr_i   (clr_high),
    .flags_o (st_high)
  );

  // Enable gating of the flags
  // low enables
  assign pend_low  = st_low & st.en_low & `MIS_EN_LOW_MASK;
  // mid enables, pulse and energy flags
  assign pend_mid  = st_mid & st.en_mid & `MIS_EN_MID_MASK;
  // high enables; reset-end has no enable
  assign pend_high = st_high & st.en_high & `MIS_EN_HIGH_MASK;

  // Summary is pure logic on flags and enables, so it drops as
  // soon as the last enabled flag is cleared, with no write
  // summary flag
  assign summary = (|pend_low) | (|pend_mid) | (|pend_high);

  // Low status as software sees it, summary in bit seven
  always_comb begin
    st_low_view = st_low;
    st_low_view[`MIS_BIT_SUMMARY] = summary;
  end

  // Read multiplexer; reserved bits read zero
  always_comb begin
    read_val = `MIS_ZERO8;
    if (hit_en_low) begin
      read_val = st.en_low;
    end
    if (hit_en_mid) begin
      read_val = st.en_mid;
    end
    if (hit_en_high) begin
      read_val = st.en_high;
    end
    if (hit_st_low) begin
      read_val = st_low_view;
    end
    if (hit_st_mid) begin
      read_val = st_mid;
    end
    if (hit_st_high) begin
      read_val = st_high;
    end
  end

  // Next state of the controller
  always_comb begin
    next_st        = st;
    next_st.rvalid = 1'b0;

    // Enable register writes, reserved bits held at zero
    if (sfr_i.wr && hit_en_low) begin
      next_st.en_low = sfr_i.wdata & `MIS_EN_LOW_MASK;
    end
    if (sfr_i.wr && hit_en_mid) begin
      next_st.en_mid = sfr_i.wdata & `MIS_EN_MID_MASK;
    end
    if (sfr_i.wr && hit_en_high) begin
      next_st.en_high = sfr_i.wdata & `MIS_EN_HIGH_MASK;
    end

    // Read data captured for the next cycle; unmapped reads
    // leave the previous read data in place with no valid strobe
    if (sfr_i.rd && any_hit) begin
      next_st.rdata  = read_val;
      next_st.rvalid = 1'b1;
    end

    // Track sign levels for change detection
    next_st.sign_q     = sign_now;
    next_st.sign_armed = 1'b1;

    // Pulse pins follow the events only while enabled
    next_st.pulse_a = event_i.freq_pulse_a &
                      freq_out_en_i[`MIS_FREQ_A];
    next_st.pulse_b = event_i.freq_pulse_b &
                      freq_out_en_i[`MIS_FREQ_B];
  end

  // State register; low ce_i freezes everything
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st.en_low     <= `MIS_EN_RST;
      st.en_mid     <= `MIS_EN_RST;
      st.en_high    <= `MIS_EN_RST;
      st.sign_q     <= '0;
      st.sign_armed <= 1'b0;
      st.rdata      <= `MIS_ZERO8;
      st.rvalid     <= 1'b0;
      st.pulse_a    <= 1'b0;
      st.pulse_b    <= 1'b0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // Outputs
  assign sfr_rdata_o    = st.rdata;
  assign sfr_rvalid_o   = st.rvalid;
  assign sfr_hit_o      = any_hit;
  assign freq_pulse_a_o = st.pulse_a;
  assign freq_pulse_b_o = st.pulse_b;
  assign irq_o = summary;
endmodule
`default_nettype wire

// [testbench/mis_irq_ctrl_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module mis_irq_ctrl_asserts (
  input  wire logic               clk_i,          // Core clock
  input  wire logic               reset_i,        // Sync reset
  input  wire logic               ce_i,           // Clock enable
  input  wire mis_pkg::mis_sfr_s   sfr_i,          // Register access
  input  wire logic [7:0]         sfr_rdata_o,    // Read data
  input  wire logic               sfr_rvalid_o,   // Read valid
  input  wire logic               sfr_hit_o,      // Decode hit
  input  wire mis_pkg::mis_sign_s  sign_i,         // Sign levels
  input  wire mis_pkg::mis_event_s event_i,        // Event pulses
  input  wire logic [1:0]         freq_out_en_i,  // Pin enables
  input  wire logic               freq_pulse_a_o, // First pulse out
  input  wire logic               freq_pulse_b_o, // Second pulse out
  input  wire logic               irq_o           // Interrupt
);
  import mis_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Accepted read, then the low status read that carries the summary
  sequence s_rd;
    ce_i && sfr_i.rd && sfr_hit_o;
  endsequence
  sequence s_rd_low;
    s_rd ##0 (sfr_i.addr == 8'hdc);
  endsequence
  AST_RD_ANSWER: assert property (s_rd |=> sfr_rvalid_o)
    else $error("read not answered");
  AST_RD_SUMMARY: assert property (
    s_rd_low |=> sfr_rdata_o[7] == $past(irq_o))
    else $error("summary bit differs from interrupt");
  AST_NO_RVALID: assert property (
    !(ce_i && sfr_i.rd && sfr_hit_o) |=> !sfr_rvalid_o)
    else $error("read valid without accepted read");
  AST_HIT: assert property (
    sfr_hit_o == (sfr_i.addr inside {[8'hd9:8'hde]}))
    else $error("address decode wrong");
  AST_STICKY: assert property (irq_o && !sfr_i.wr |=> irq_o)
    else $error("interrupt dropped without a write");
  AST_IRQ_CAUSE: assert property ($rose(irq_o) |-> $past(ce_i) &&
    ($past(sfr_i.wr) || $past(|event_i) || $past(sign_i) != $past(sign_i, 2)
     || $past(sign_i, 2) != $past(sign_i, 3)))
    else $error("interrupt rose without cause");
  AST_PULSE_A: assert property (
    ce_i && event_i.freq_pulse_a && freq_out_en_i[0] |=> freq_pulse_a_o)
    else $error("first pulse pin missed");
  AST_PULSE_B_IDLE: assert property (
    ce_i && !(event_i.freq_pulse_b && freq_out_en_i[1]) |=> !freq_pulse_b_o)
    else $error("second pulse pin without cause");
  AST_RDATA_HOLD: assert property (
    !(ce_i && sfr_i.rd && sfr_hit_o) |=> $stable(sfr_rdata_o))
    else $error("read data moved without read");
  AST_FREEZE: assert property (!ce_i |=> $stable(irq_o))
    else $error("interrupt moved while frozen");
endmodule
`default_nettype wire

// [testbench/mis_core_model.sv]
`timescale 1ns/1ns
`default_nettype none
module mis_core_model (
  input  wire logic        clk_i,    // Core clock
  input  wire logic [7:0]  rdata_i,  // Read data
  input  wire logic        rvalid_i, // Read valid
  output mis_pkg::mis_sfr_s sfr_o     // Register access
);
  import mis_pkg::*;
  // Idle bus starts at zero and carries inverted values after each access, so stale decode is never trusted
  initial sfr_o = '{addr: 8'h00, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    sfr_o = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk_i);
    sfr_o = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask
  // Unanswered read yields unknown data so it never matches
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    @(negedge clk_i);
    sfr_o = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk_i);
    ok = rvalid_i;
    d = rvalid_i ? rdata_i : 8'hxx;
    sfr_o = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
  endtask
endmodule
`default_nettype wire

// [testbench/test_mis_irq_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
module test_mis_irq_ctrl;
  import mis_pkg::*;
  logic       clk_i, reset_i, ce_i, hit, rvalid, pa, pb, irq, ok;
  logic [7:0] rdata, d, a, m;
  logic [1:0] fen;
  mis_sfr_s   sfr;
  mis_sign_s  sg;
  mis_event_s ev;
  int         miscompares = 0;
  int         comparisons = 0;
  int         cycles = 0;
  // Event index row: status offset, flag mask
  logic [15:0] rows [18] = '{16'hde01, 16'hde02, 16'hde04, 16'hde08,
    16'hde10, 16'hde20, 16'hde80, 16'hdd01, 16'hdd02, 16'hdd04, 16'hdd08,
    16'hdd10, 16'hdd20, 16'hdd40, 16'hdd80, 16'hdc01, 16'hdc02, 16'hdc04};

  mis_irq_ctrl i_mis_irq_ctrl (.clk_i(clk_i), .reset_i(reset_i),
    .ce_i(ce_i), .sfr_i(sfr), .sfr_rdata_o(rdata), .sfr_rvalid_o(rvalid),
    .sfr_hit_o(hit), .sign_i(sg), .event_i(ev), .freq_out_en_i(fen),
    .freq_pulse_a_o(pa), .freq_pulse_b_o(pb), .irq_o(irq));
  mis_core_model i_mis_core_model (.clk_i(clk_i), .rdata_i(rdata),
    .rvalid_i(rvalid), .sfr_o(sfr));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  // Decode seen on every read against the six documented offsets
  always @(posedge clk_i) begin
    if (sfr.rd) begin
      chk("hit", 8'(sfr.addr >= 8'hd9 && sfr.addr <= 8'hde), {7'h0, hit});
    end
  end

  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic ci(input logic e);
    chk("irq", {7'h0, e}, {7'h0, irq});
  endtask
  // One-cycle event pulse, returns in the cycle after it was taken
  task automatic fire(input int i);
    @(negedge clk_i);
    ev = mis_event_s'(18'h1 << i);
    @(negedge clk_i);
    ev = '0;
  endtask

  initial begin
    reset_i = 1'b1;
    ce_i = 1'b1;
    fen = 2'b00;
    sg = '0;
    ev = '0;
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    // Reset values of all six registers
    for (int j = 0; j < 6; j++) begin
      i_mis_core_model.rd(8'hd9 + 8'(j), d, ok);
      chk("reset value", (j == 5) ? 8'h80 : 8'h00, d);
    end
    // Every event: masked, then enabled, then cleared
    for (int i = 0; i < 18; i++) begin
      a = rows[i][15:8];
      m = rows[i][7:0];
      i_mis_core_model.wr(a, 8'h00);
      i_mis_core_model.wr(a - 8'h03, 8'h00);
      fire(i);
      ci(1'b0);
      i_mis_core_model.wr(a - 8'h03, m);
      ci(i != 6);
      i_mis_core_model.rd(a, d, ok);
      chk("status", m | ((a == 8'hdc) ? 8'h80 : 8'h00), d);
      i_mis_core_model.wr(a, ~m);
      ci(1'b0);
    end
    // Reserved enable bits read zero
    for (int j = 0; j < 3; j++) begin
      i_mis_core_model.wr(8'hd9 + 8'(j), 8'hff);
      i_mis_core_model.rd(8'hd9 + 8'(j), d, ok);
      chk("enable", (j == 1) ? 8'hff : 8'h3f, d);
    end
    // Sign changes of each level
    for (int k = 0; k < 3; k++) begin
      @(negedge clk_i);
      sg = mis_sign_s'(sg ^ (3'h1 << k));
      repeat (2) @(negedge clk_i);
      i_mis_core_model.rd(8'hdc, d, ok);
      chk("sign flag", 8'h80 | (8'h08 << k), d);
      i_mis_core_model.wr(8'hdc, 8'h00);
      ci(1'b0);
    end
    // Pulse pins follow their enables
    fen = 2'b01;
    fire(13);
    chk("pin a", 8'h01, {7'h0, pa});
    fire(14);
    chk("pin b", 8'h00, {7'h0, pb});
    chk("pin a idle", 8'h00, {7'h0, pa});
    fen = 2'b10;
    fire(14);
    chk("pin b on", 8'h01, {7'h0, pb});
    ci(1'b1);
    i_mis_core_model.wr(8'hdd, 8'h00);
    ci(1'b0);
    // Low clock enable freezes state, so an event is lost
    ce_i = 1'b0;
    fire(0);
    ce_i = 1'b1;
    ci(1'b0);
    i_mis_core_model.rd(8'hde, d, ok);
    chk("frozen", 8'h00, d);
    // Unmapped address gives no answer
    i_mis_core_model.rd(8'hdf, d, ok);
    chk("unmapped", 8'h00, {7'h0, ok});
    // Reset in mid-run marks its end and drops enables
    @(negedge clk_i);
    reset_i = 1'b1;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    i_mis_core_model.rd(8'hde, d, ok);
    chk("reset end", 8'h80, d);
    i_mis_core_model.rd(8'hdb, d, ok);
    chk("enable high", 8'h00, d);
    print_verdict();
  end
endmodule

bind mis_irq_ctrl mis_irq_ctrl_asserts i_mis_irq_ctrl_asserts (
  .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .sfr_i(sfr_i),
  .sfr_rdata_o(sfr_rdata_o), .sfr_rvalid_o(sfr_rvalid_o),
  .sfr_hit_o(sfr_hit_o), .sign_i(sign_i), .event_i(event_i),
  .freq_out_en_i(freq_out_en_i), .freq_pulse_a_o(freq_pulse_a_o),
  .freq_pulse_b_o(freq_pulse_b_o), .irq_o(irq_o));
`default_nettype wire
